// >>> bench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  // ------------------------------------------------------------
  // shortened delay counts keep the run short
  // ------------------------------------------------------------
  localparam int          LONG_L  = 32;
  localparam int          SHORT_L = 8;
  localparam logic [31:0] MASK    = 32'hFFFF_F0FF;

  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  option_byte0;
  logic [7:0]  option_byte1;
  logic        main_osc_ready;
  logic        cpu_reset_n;
  logic        halt_exit_busy;
  logic [1:0]  package_code;
  logic [1:0]  clock_source_sel;
  logic [2:0]  resonator_drive;
  logic [2:0]  freq_range_sel;
  logic        doubler_enable;
  logic        clock_filter_enable;
  logic        backup_osc_enable;
  logic [31:0] pad_pullup_force;
  logic [31:0] rd;
  logic        err;
  int          n_mismatch;
  int          total_checks;

  option_clock_reset_config #(.NUM_PORTS(4), .BONDED_MASK(MASK), .LONG_DELAY(LONG_L),
    .SHORT_DELAY(SHORT_L)) option_clock_reset_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .option_byte0(option_byte0), .option_byte1(option_byte1),
    .main_osc_ready(main_osc_ready), .cpu_reset_n(cpu_reset_n),
    .halt_exit_busy(halt_exit_busy), .package_code(package_code),
    .clock_source_sel(clock_source_sel), .resonator_drive(resonator_drive),
    .freq_range_sel(freq_range_sel), .doubler_enable(doubler_enable),
    .clock_filter_enable(clock_filter_enable), .backup_osc_enable(backup_osc_enable),
    .pad_pullup_force(pad_pullup_force));

  // 40 MHz clock
  initial pclk = 1'b0;
  always #12.5 pclk = ~pclk;

  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // option bytes are set while reset is held, so they are stable at release
  task automatic do_reset(input logic [7:0] b0, input logic [7:0] b1, input logic osc);
    @(posedge pclk);
    presetn        <= 1'b0;
    option_byte0   <= b0;
    option_byte1   <= b1;
    main_osc_ready <= osc;
    repeat (6) @(posedge pclk);
    #1 chk(cpu_reset_n, 0);
    chk(pad_pullup_force, 32'hFFFF_FFFF);
    @(posedge pclk);
    presetn <= 1'b1;
  endtask

  // edges until the core leaves reset must fall in the window
  task automatic wait_run(input int lo, input int hi);
    int n;
    n = 0;
    while (cpu_reset_n !== 1'b1 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'b0, (n >= lo && n <= hi)}, 1);
  endtask

  task automatic chk_dec(input logic [7:0] b0, input logic [7:0] b1);
    logic res;
    res = (b1[5:4] == 2'b00);
    chk(package_code, {b1[7], b0[1]});
    chk(clock_source_sel, b1[5:4]);
    chk(resonator_drive, res ? b1[3:1] : 3'b000);
    chk(freq_range_sel, res ? 3'b000 : b1[3:1]);
    chk(doubler_enable, !b1[0]);
    chk(clock_filter_enable, !b0[5]);
    chk(backup_osc_enable, !b0[5]);
    chk(pad_pullup_force, ({b1[7], b0[1]} == 2'b00) ? ~MASK : 32'hFFFF_FFFF);
  endtask

  // watchdog: the whole sequence needs under a thousand cycles
  initial begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    conclude;
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0] b1;
    logic       mis;
    int         n;
    n_mismatch = 0;
    total_checks = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    option_byte0 = 8'h00;
    option_byte1 = 8'h42;
    main_osc_ready = 1'b0;

    // short delay, security on: counts without the main oscillator
    // external clock source, so the short delay is a fair choice
    do_reset(8'h00, 8'h72, 1'b0);
    wait_run(SHORT_L + 4, SHORT_L + 10);
    chk_dec(8'h00, 8'h72);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0072);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'hFFFF_FFFF);
    chk(err, 0);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_0072);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(err, 1);
    $display("test short_delay done");

    // halt exit uses the same short count
    apb(1'b1, 8'h08, 32'h0000_0001);
    n = 0;
    @(posedge pclk);
    #1 chk(halt_exit_busy, 1);
    while (halt_exit_busy !== 1'b0 && n < 5000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'b0, (n >= SHORT_L - 2 && n <= SHORT_L + 6)}, 1);
    apb(1'b0, 8'h08, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    $display("test halt_exit done");

    // every source with every range, doubler on to exercise the misuse flag
    for (int s = 0; s < 4; s++) begin
      for (int r = 0; r < 4; r++) begin
        // a resonator gets the long delay, as a careful configurer would pick
        b1 = {1'b0, (s != 0), 2'(s), 3'(r), 1'b0};
        mis = (s == 2) || (r != 1);
        do_reset(8'h00, b1, 1'b0);
        wait_run((s == 0) ? LONG_L + 4 : SHORT_L + 4,
                 (s == 0) ? LONG_L + 10 : SHORT_L + 10);
        chk_dec(8'h00, b1);
        apb(1'b0, 8'h04, 32'h0000_0000);
        chk(rd, {28'b0, mis, 3'b011});
      end
    end
    $display("test source_range done");

    // long delay, security off: waits for the oscillator, other package
    do_reset(8'h22, 8'hB5, 1'b0);
    repeat (LONG_L + 20) @(posedge pclk);
    #1 chk(cpu_reset_n, 0);
    apb(1'b0, 8'h04, 32'h0000_0000);
    chk(rd, 32'h0000_0011);
    @(posedge pclk);
    main_osc_ready <= 1'b1;
    wait_run(LONG_L + 2, LONG_L + 10);
    chk_dec(8'h22, 8'hB5);
    $display("test long_delay done");

    // option bytes changed after the latch must not reach the outputs
    @(posedge pclk);
    option_byte0 <= 8'h00;
    option_byte1 <= 8'h4E;
    repeat (10) @(posedge pclk);
    #1 chk_dec(8'h22, 8'hB5);
    apb(1'b0, 8'h00, 32'h0000_0000);
    chk(rd, 32'h0000_22B5);
    $display("test static_latch done");
    conclude;
  end
endmodule

`default_nettype wire

// >>> rtl/option_clock_pkg.sv
package option_clock_pkg;

  typedef logic [1:0] clk_src_t;

  // layout of the second configuration byte, msb first
  typedef struct packed {
    logic       package_select_hi;
    logic       reset_delay_select;
    clk_src_t   clock_source_type;
    logic [2:0] oscillator_freq_range;
    logic       doubler_off;
  } option_byte1_s;

  typedef enum logic [2:0] {
    S_SETTLE,
    S_LATCH,
    S_WAIT_OSC,
    S_COUNT,
    S_RUN
  } delay_state_e;

endpackage

// >>> rtl/option_clock_regs.svh
`ifndef OPTION_CLOCK_REGS_SVH
`define OPTION_CLOCK_REGS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define ADDR_W             8
`define OFF_CONFIG         8'h00
`define OFF_STATUS         8'h04
`define OFF_HALT_CTRL      8'h08
`define OFF_COUNT          8'h0C

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define OPT0_CSS_BIT       5
`define OPT0_PKG_LO_BIT    1
`define CFG_BYTE0_LSB      8
`define HALT_START_BIT     0
`define STS_LATCHED_BIT    0
`define STS_RUN_BIT        1
`define STS_HALT_BIT       2
`define STS_MISCFG_BIT     3
`define STS_WAIT_OSC_BIT   4

// ----------------------------------------------------------------
// encodings and counts
// ----------------------------------------------------------------
`define PKG_TQFP44         2'b00
`define SRC_RESONATOR      2'b00
`define SRC_EXT_RC         2'b01
`define SRC_INT_RC         2'b10
`define SRC_EXT_CLOCK      2'b11
`define RANGE_1_TO_2MHZ    3'b000
`define RANGE_2_TO_4MHZ    3'b001
`define RANGE_4_TO_8MHZ    3'b010
`define RANGE_8_TO_16MHZ   3'b011
`define RESET_DELAY_LONG   4096
`define RESET_DELAY_SHORT  256
`define SETTLE_CYCLES      2'd2
`define BYTE_RESET         8'h00

`endif

// >>> rtl/option_clock_reset_config.sv
// How it works
// - both package bits together pick bonding; 00 means the 44-pin package
// - pads without a bonded pin leave reset as inputs with pull-up
// - delay select bit: 0 counts 4096 cycles, 1 counts 256, reset and halt exit
// - with clock security on, counting starts at once without waiting for oscillator
// - source field: 00 resonator, 01 external RC, 10 internal RC, 11 external clock
// - resonator selected: range field sets drive current for 1-2 to 8-16 MHz
// - other sources: range field names the operating frequency range instead
// - security bit 0 enables clock filter and backup oscillator, 1 disables both
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "option_clock_regs.svh"

module option_clock_reset_config #(
  parameter int                      NUM_PORTS   = 4,
  parameter logic [NUM_PORTS*8-1:0]  BONDED_MASK = '1,
  parameter int                      LONG_DELAY  = `RESET_DELAY_LONG,
  parameter int                      SHORT_DELAY = `RESET_DELAY_SHORT
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`ADDR_W-1:0]     paddr,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic [7:0]             option_byte0,
  input  wire logic [7:0]             option_byte1,
  input  wire logic                   main_osc_ready,
  output logic                        cpu_reset_n,
  output logic                        halt_exit_busy,
  output logic      [1:0]             package_code,
  output logic      [1:0]             clock_source_sel,
  output logic      [2:0]             resonator_drive,
  output logic      [2:0]             freq_range_sel,
  output logic                        doubler_enable,
  output logic                        clock_filter_enable,
  output logic                        backup_osc_enable,
  output logic      [NUM_PORTS*8-1:0] pad_pullup_force
);

  localparam int CW = $clog2(LONG_DELAY + 1);
  initial begin
    if (NUM_PORTS < 1 || SHORT_DELAY < 2 || LONG_DELAY < SHORT_DELAY) begin
      $error("option_clock_reset_config: unusable parameters");
    end
  end

  logic [7:0]                  byte0_meta, byte0_sync;
  logic [7:0]                  byte1_meta, byte1_sync;
  logic                        osc_meta, osc_sync;
  logic [7:0]                  opt0_reg;
  option_clock_pkg::option_byte1_s opt1_reg;
  option_clock_pkg::option_byte1_s opt1_next;
  option_clock_pkg::delay_state_e  state_reg;
  logic [1:0]                  settle_reg;
  logic                        latched_reg;
  logic                        miscfg_reg;
  logic                        cnt_start, cnt_busy, cnt_done;
  logic [CW-1:0]               cnt_load, cnt_value;
  logic                        apb_access, apb_commit, halt_start;
  logic [31:0]                 rdata_next;
  logic                        unmapped;
  logic                        css_on;

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  // option storage and oscillator status arrive from outside this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      byte0_meta <= `BYTE_RESET;
      byte0_sync <= `BYTE_RESET;
      byte1_meta <= `BYTE_RESET;
      byte1_sync <= `BYTE_RESET;
      osc_meta   <= 1'b0;
      osc_sync   <= 1'b0;
    end else begin
      byte0_meta <= option_byte0;
      byte0_sync <= byte0_meta;
      byte1_meta <= option_byte1;
      byte1_sync <= byte1_meta;
      osc_meta   <= main_osc_ready;
      osc_sync   <= osc_meta;
    end
  end

  assign opt1_next = option_clock_pkg::option_byte1_s'(byte1_sync);
  assign css_on    = !opt0_reg[`OPT0_CSS_BIT];

  // ----------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------
  // counting waits for the oscillator only when security is off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg  <= option_clock_pkg::S_SETTLE;
      settle_reg <= '0;
    end else begin
      case (state_reg)
        option_clock_pkg::S_SETTLE: begin
          settle_reg <= settle_reg + 2'd1;
          if (settle_reg == `SETTLE_CYCLES) begin
            state_reg <= option_clock_pkg::S_LATCH;
          end
        end
        option_clock_pkg::S_LATCH: state_reg <= option_clock_pkg::S_WAIT_OSC;
        option_clock_pkg::S_WAIT_OSC: begin
          if (cnt_start) begin
            state_reg <= option_clock_pkg::S_COUNT;
          end
        end
        option_clock_pkg::S_COUNT: begin
          if (cnt_done) begin
            state_reg <= option_clock_pkg::S_RUN;
          end
        end
        option_clock_pkg::S_RUN: begin
          if (halt_start) begin
            state_reg <= option_clock_pkg::S_WAIT_OSC;
          end
        end
        default: state_reg <= option_clock_pkg::S_SETTLE;
      endcase
    end
  end

  assign cnt_start = (state_reg == option_clock_pkg::S_WAIT_OSC) && (css_on || osc_sync);
  assign cnt_load  = opt1_reg.reset_delay_select ? CW'(SHORT_DELAY) : CW'(LONG_DELAY);

  reset_delay_counter #(
    .WIDTH (CW)
  ) u_delay (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (cnt_start),
    .load    (cnt_load),
    .busy    (cnt_busy),
    .done    (cnt_done),
    .count   (cnt_value)
  );

  // ----------------------------------------------------------------
  // one-time capture and decode of the option bytes
  // ----------------------------------------------------------------
  // capture only in S_LATCH; later changes of storage are ignored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latched_reg         <= 1'b0;
      opt0_reg            <= `BYTE_RESET;
      opt1_reg            <= option_clock_pkg::option_byte1_s'(`BYTE_RESET);
      package_code        <= '0;
      clock_source_sel    <= '0;
      resonator_drive     <= '0;
      freq_range_sel      <= '0;
      doubler_enable      <= 1'b0;
      clock_filter_enable <= 1'b0;
      backup_osc_enable   <= 1'b0;
      pad_pullup_force    <= '1;
      miscfg_reg          <= 1'b0;
    end else if (state_reg == option_clock_pkg::S_LATCH) begin
      latched_reg         <= 1'b1;
      opt0_reg            <= byte0_sync;
      opt1_reg            <= opt1_next;
      package_code        <= {opt1_next.package_select_hi, byte0_sync[`OPT0_PKG_LO_BIT]};
      clock_source_sel    <= opt1_next.clock_source_type;
      doubler_enable      <= !opt1_next.doubler_off;
      clock_filter_enable <= !byte0_sync[`OPT0_CSS_BIT];
      backup_osc_enable   <= !byte0_sync[`OPT0_CSS_BIT];
      // resonator takes the range as drive current, others as operating range
      if (opt1_next.clock_source_type == `SRC_RESONATOR) begin
        resonator_drive <= opt1_next.oscillator_freq_range;
        freq_range_sel  <= '0;
      end else begin
        resonator_drive <= '0;
        freq_range_sel  <= opt1_next.oscillator_freq_range;
      end
      // unknown package codes bond nothing, so every pad is pulled up
      if ({opt1_next.package_select_hi, byte0_sync[`OPT0_PKG_LO_BIT]} == `PKG_TQFP44) begin
        pad_pullup_force <= ~BONDED_MASK;
      end else begin
        pad_pullup_force <= '1;
      end
      // flags only; the hardware does not override a bad doubler choice
      miscfg_reg <= !opt1_next.doubler_off &&
                    ((opt1_next.clock_source_type == `SRC_INT_RC) ||
                     (opt1_next.oscillator_freq_range != `RANGE_2_TO_4MHZ));
    end
  end

  // ----------------------------------------------------------------
  // core reset and halt exit outputs
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cpu_reset_n    <= 1'b0;
      halt_exit_busy <= 1'b0;
    end else begin
      if (cnt_done) begin
        cpu_reset_n    <= 1'b1;
        halt_exit_busy <= 1'b0;
      end else if (halt_start) begin
        halt_exit_busy <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait state
  // ----------------------------------------------------------------
  assign apb_access = psel && penable && !pready;
  assign apb_commit = psel && penable && pready;
  assign halt_start = apb_commit && pwrite && (paddr == `OFF_HALT_CTRL) &&
                      pwdata[`HALT_START_BIT] && (state_reg == option_clock_pkg::S_RUN);

  // read mux; unmapped addresses return zero with an error
  always_comb begin
    rdata_next = '0;
    unmapped   = 1'b0;
    case (paddr)
      `OFF_CONFIG: begin
        rdata_next[7:0]                 = opt1_reg;
        rdata_next[`CFG_BYTE0_LSB +: 8] = opt0_reg;
      end
      `OFF_STATUS: begin
        rdata_next[`STS_LATCHED_BIT]  = latched_reg;
        rdata_next[`STS_RUN_BIT]      = cpu_reset_n;
        rdata_next[`STS_HALT_BIT]     = halt_exit_busy;
        rdata_next[`STS_MISCFG_BIT]   = miscfg_reg;
        rdata_next[`STS_WAIT_OSC_BIT] = (state_reg == option_clock_pkg::S_WAIT_OSC);
      end
      `OFF_HALT_CTRL: rdata_next = '0;
      `OFF_COUNT:     rdata_next[CW-1:0] = cnt_value;
      default:        unmapped = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_access;
      pslverr <= apb_access && unmapped;
      if (apb_access && !pwrite) begin
        prdata <= rdata_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence latch_done_s;
    $rose(latched_reg);
  endsequence
  sequence wait_css_s;
    (state_reg == option_clock_pkg::S_WAIT_OSC) && css_on;
  endsequence
  package_code_a: assert property (latch_done_s |-> package_code ==
    {opt1_reg.package_select_hi, opt0_reg[`OPT0_PKG_LO_BIT]}) else $error("package code wrong");
  pad_pullup_a: assert property (latch_done_s ##0 (package_code == `PKG_TQFP44)
    |-> pad_pullup_force == ~BONDED_MASK) else $error("pad pull-up wrong");
  css_start_a: assert property (wait_css_s |=> cnt_busy ##0
    (state_reg == option_clock_pkg::S_COUNT)) else $error("count did not start");
  osc_wait_a: assert property ((state_reg == option_clock_pkg::S_WAIT_OSC) && !css_on
    && !osc_sync |=> !cnt_busy) else $error("count started without oscillator");
  source_sel_a: assert property (latched_reg |-> clock_source_sel ==
    opt1_reg.clock_source_type) else $error("clock source wrong");
  drive_range_a: assert property (latched_reg && clock_source_sel == `SRC_RESONATOR
    |-> resonator_drive == opt1_reg.oscillator_freq_range && freq_range_sel == '0)
    else $error("resonator drive wrong");
  freq_range_a: assert property (latched_reg && clock_source_sel != `SRC_RESONATOR
    |-> freq_range_sel == opt1_reg.oscillator_freq_range && resonator_drive == '0)
    else $error("frequency range wrong");
  doubler_sel_a: assert property (latched_reg |-> doubler_enable !=
    opt1_reg.doubler_off) else $error("doubler enable wrong");
  css_outputs_a: assert property (latched_reg |-> clock_filter_enable == css_on &&
    backup_osc_enable == css_on) else $error("security outputs wrong");
  config_static_a: assert property (latched_reg |=> $stable(opt1_reg) &&
    $stable(opt0_reg) && $stable(pad_pullup_force)) else $error("configuration changed");
  reset_release_a: assert property ($rose(cpu_reset_n) |-> $past(cnt_done))
    else $error("core reset released early");

endmodule

`default_nettype wire

// >>> rtl/reset_delay_counter.sv
`timescale 1ns/10ps
`default_nettype none

module reset_delay_counter #(
  parameter int WIDTH = 13
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load,
  output logic                  busy,
  output logic                  done,
  output logic [WIDTH-1:0]      count
);

  initial begin
    if (WIDTH < 2) begin
      $error("reset_delay_counter: WIDTH too small");
    end
  end

  // ----------------------------------------------------------------
  // down counter, done one cycle after reaching zero
  // ----------------------------------------------------------------
  // load-1 is held so that exactly load cycles pass before done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy  <= 1'b0;
      done  <= 1'b0;
      count <= '0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy  <= 1'b1;
        count <= load - WIDTH'(1);
      end else if (busy) begin
        if (count == '0) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count - WIDTH'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  logic [WIDTH:0] run_len_reg;

  // edges seen busy since start; zero at the start edge itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_len_reg <= '0;
    end else if (start) begin
      run_len_reg <= '0;
    end else if (busy) begin
      run_len_reg <= run_len_reg + (WIDTH+1)'(1);
    end
  end

  delay_length_a: assert property (@(posedge pclk) disable iff (!presetn)
    done |-> run_len_reg == {1'b0, load}) else $error("reset delay length wrong");

endmodule

`default_nettype wire
